//--- logic/vsbs_board_select.sv
// Top: registered board select, register index and acknowledge
`timescale 1ns/100ps
`default_nettype none
module vsbs_board_select
    import vsbs_pkg::*;
(
    input  wire logic           clk_sys,        // 20 MHz clock
    input  wire logic           rst,            // Synchronous reset, high
    input  wire logic           ce,             // Clock enable
    input  wire logic           asValid,        // Address strobe valid
    input  wire logic           dsValid,        // Data strobe valid
    input  wire logic [15:1]    addr,           // A15..A01
    input  wire logic [5:0]     am,             // Address modifier
    input  wire logic [8:0]     upper_base_address_jumpers_fitted, // A15..A08 jumpers, bits 8:1
    input  wire logic           low_base_address_jumper_fitted,     // A07 jumper
    input  wire logic           privilege_select_jumper_fitted,     // Nonprivileged when fitted
    output logic                boardSel,       // Board selected
    output logic [5:0]          regIdx,         // Selected register index
    output logic                outputReg,      // Selected register is an output code
    output logic                dtack           // Transfer acknowledge
);
    vsbs_sel_if sel ();

    // Decode widths must cover A15..A01 exactly
    if (BASE_BITS + BASE_LSB != 16 || REG_BITS + REG_LSB != BASE_LSB) begin : g_bad_width
        $error("decode widths do not cover the address bus");
    end

    wire logic [8:0] fitted = {upper_base_address_jumpers_fitted[8:1], low_base_address_jumper_fitted};

    vsbs_decode u_dec (
        .addr       (addr),
        .am         (am),
        .baseFitted (fitted),
        .privFitted (privilege_select_jumper_fitted),
        .sel        (sel)
    );

    wire logic next_boardSel = asValid && sel.hit;

    // ************************************************************
    // Registered outputs
    // ************************************************************
    // sixty-four locations
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            boardSel  <= 1'b0;
            regIdx    <= 6'h00;
            outputReg <= 1'b0;
            dtack     <= 1'b0;
        end else if (ce) begin
            boardSel  <= next_boardSel;
            regIdx    <= next_boardSel ? sel.regIdx : regIdx;
            outputReg <= next_boardSel && sel.isOutput;
            dtack     <= next_boardSel && dsValid;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    // Access taken with matching address and modifier
    sequence s_hit_taken;
        ce && next_boardSel;
    endsequence

    // Access offered with a modifier the board never answers
    sequence s_am_foreign;
        ce && asValid && am != AM_SHORT_SUPER && am != AM_SHORT_NPRIV;
    endsequence

    // Frozen cycle
    sequence s_frozen;
        !ce;
    endsequence

    property p_sel_match;
        @(posedge clk_sys) disable iff (rst)
        ce && asValid && addr[15:7] != ~fitted |=> !boardSel;
    endproperty
    a_sel_match: assert property (p_sel_match) else $error("select on wrong base");

    property p_jumper_zero;
        @(posedge clk_sys) disable iff (rst)
        ce && asValid && addr[15:7] == ~fitted && am == (privilege_select_jumper_fitted ? AM_SHORT_NPRIV : AM_SHORT_SUPER)
        |=> boardSel;
    endproperty
    a_jumper_zero: assert property (p_jumper_zero) else $error("missed matching access");

    property p_reg_idx;
        @(posedge clk_sys) disable iff (rst)
        ce && next_boardSel |=> regIdx == $past(addr[6:1]);
    endproperty
    a_reg_idx: assert property (p_reg_idx) else $error("wrong register index");

    property p_priv;
        @(posedge clk_sys) disable iff (rst)
        ce && am == AM_SHORT_SUPER && privilege_select_jumper_fitted |=> !boardSel;
    endproperty
    a_priv: assert property (p_priv) else $error("supervisory answered when fitted");

    property p_factory;
        @(posedge clk_sys) disable iff (rst)
        ce && asValid && fitted == FACTORY_JUMPERS_FITTED && addr[15:7] == 9'h000
        && !privilege_select_jumper_fitted && am == AM_SHORT_SUPER |=> boardSel;
    endproperty
    a_factory: assert property (p_factory) else $error("factory base not answered");

    property p_outreg;
        @(posedge clk_sys) disable iff (rst)
        boardSel |-> outputReg == regIdx[5];
    endproperty
    a_outreg: assert property (p_outreg) else $error("output range flag wrong");

    property p_sel_hold;
        @(posedge clk_sys) disable iff (rst)
        !ce ##1 !ce |-> $stable(boardSel);
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("state moved while frozen");

    property p_no_ack;
        @(posedge clk_sys) disable iff (rst)
        dtack |-> boardSel;
    endproperty
    a_no_ack: assert property (p_no_ack) else $error("acknowledge without select");

    // ************************************************************
    // Modifier, strobe, index, freeze and reset checks
    // ************************************************************
    // foreign modifier ignored
    property p_am_foreign;
        @(posedge clk_sys) disable iff (rst)
        s_am_foreign |=> !boardSel && !dtack;
    endproperty
    a_am_foreign: assert property (p_am_foreign) else $error("foreign modifier answered");

    property p_hit_answer;
        @(posedge clk_sys) disable iff (rst)
        s_hit_taken |=> boardSel;
    endproperty
    a_hit_answer: assert property (p_hit_answer) else $error("hit not selected");

    property p_ack_data;
        @(posedge clk_sys) disable iff (rst)
        s_hit_taken ##0 dsValid |=> dtack;
    endproperty
    a_ack_data: assert property (p_ack_data) else $error("hit with data not acknowledged");

    property p_addr_only;
        @(posedge clk_sys) disable iff (rst)
        ce && !dsValid |=> !dtack;
    endproperty
    a_addr_only: assert property (p_addr_only) else $error("acknowledge without data strobe");

    property p_idx_hold;
        @(posedge clk_sys) disable iff (rst)
        ce && !next_boardSel |=> $stable(regIdx);
    endproperty
    a_idx_hold: assert property (p_idx_hold) else $error("index moved without hit");

    property p_out_clear;
        @(posedge clk_sys) disable iff (rst)
        !boardSel |-> !outputReg;
    endproperty
    a_out_clear: assert property (p_out_clear) else $error("output flag without select");

    property p_index_range;
        @(posedge clk_sys) disable iff (rst)
        boardSel && outputReg |-> regIdx >= OUT_FIRST_IDX;
    endproperty
    a_index_range: assert property (p_index_range) else $error("output flag below output range");

    property p_low_index;
        @(posedge clk_sys) disable iff (rst)
        boardSel && !outputReg |-> regIdx < OUT_FIRST_IDX;
    endproperty
    a_low_index: assert property (p_low_index) else $error("output range not flagged");

    property p_freeze_idx;
        @(posedge clk_sys) disable iff (rst)
        s_frozen |=> $stable(regIdx);
    endproperty
    a_freeze_idx: assert property (p_freeze_idx) else $error("index moved while frozen");

    property p_freeze_ack;
        @(posedge clk_sys) disable iff (rst)
        s_frozen |=> $stable(dtack) && $stable(outputReg);
    endproperty
    a_freeze_ack: assert property (p_freeze_ack) else $error("acknowledge moved while frozen");

    property p_reset_idle;
        @(posedge clk_sys)
        rst |=> !boardSel && !dtack && !outputReg && regIdx == 6'h00;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
endmodule : vsbs_board_select
`default_nettype wire

//--- logic/vsbs_pkg.sv
// Package with decode constants for the short I/O board select
//
// Contract
// - Select only when address bits A07..A15 equal the nine jumper base bits.
// - A fitted jumper reads as zero, an absent jumper as one.
// - Six lower address lines pick the on-board register of a selected access.
// - Privilege jumper absent: supervisory short only; fitted: nonprivileged short only.
// - Factory jumpers give base address zero with supervisory access.
// - Thirty-two 16-bit output code registers sit at even offsets 40 to 7E hex.
// - Board decodes 64 contiguous 16-bit locations offset from base.
package vsbs_pkg;
    localparam int          BASE_BITS      = 9;
    localparam int          BASE_LSB       = 7;
    localparam int          REG_BITS       = 6;
    localparam int          REG_LSB        = 1;
    localparam logic [5:0]  AM_SHORT_SUPER = 6'h2D;
    localparam logic [5:0]  AM_SHORT_NPRIV = 6'h29;
    localparam int          AM_PRIV_BIT    = 2;
    localparam logic [5:0]  OUT_FIRST_IDX  = 6'h20;
    localparam logic [8:0]  FACTORY_JUMPERS_FITTED = 9'h1FF;
    localparam int          CLK_HZ         = 20000000;
    localparam int          READBACK_US    = 3400;
    localparam int          CONVERT_US     = 5000;
    localparam int          READBACK_CYC   = READBACK_US * (CLK_HZ / 1000000);
    localparam int          CONVERT_CYC    = CONVERT_US * (CLK_HZ / 1000000);
endpackage : vsbs_pkg

//--- logic/vsbs_sel_if.sv
// Interface carrying the decode result to the acknowledge stage
`timescale 1ns/100ps
`default_nettype none
interface vsbs_sel_if;
    logic       hit;
    logic [5:0] regIdx;
    logic       isOutput;
    modport dec (output hit, output regIdx, output isOutput);
    modport use_ (input hit, input regIdx, input isOutput);
endinterface : vsbs_sel_if
`default_nettype wire

//--- logic/vsbs_decode.sv
// Combinational compare of address and modifier against jumpers
`timescale 1ns/100ps
`default_nettype none
module vsbs_decode
    import vsbs_pkg::*;
(
    input  wire logic [15:1]    addr,           // Bus address A15..A01
    input  wire logic [5:0]     am,             // Address modifier
    input  wire logic [8:0]     baseFitted,     // Jumper fitted per base bit, A15..A07
    input  wire logic           privFitted,     // Privilege jumper fitted
    vsbs_sel_if.dec             sel             // Decode result
);
    // ************************************************************
    // Decode
    // ************************************************************
    // fitted reads zero
    wire logic [8:0] baseValue = ~baseFitted;
    wire logic       addrMatch = (addr[15:7] == baseValue);
    wire logic [5:0] amWanted  = privFitted ? AM_SHORT_NPRIV : AM_SHORT_SUPER;
    wire logic       amMatch   = (am == amWanted);
    assign sel.hit = addrMatch && amMatch;
    assign sel.regIdx = addr[6:1];
    assign sel.isOutput = addr[6];
endmodule : vsbs_decode
`default_nettype wire

//--- testbench/vsbs_master_model.sv
// Bus master model issuing short I/O cycles
`timescale 1ns/100ps
`default_nettype none
module vsbs_master_model (
    input  wire logic        clk_sys, // Clock
    output var  logic        asValid, // Address strobe
    output var  logic        dsValid, // Data strobe
    output var  logic [15:1] addr,    // Address
    output var  logic [5:0]  am       // Modifier
);
    initial begin
        asValid = 1'b0;
        dsValid = 1'b0;
        addr = 15'h7FFF;
        am = 6'h00;
    end
    task automatic access(input logic [15:1] a, input logic [5:0] m, input logic d);
        @(posedge clk_sys) #1;
        addr = a;
        am = m;
        asValid = 1'b1;
        dsValid = d;
        @(posedge clk_sys) #1;
        addr = ~a;
        am = ~m;
        asValid = 1'b0;
        dsValid = 1'b0;
    endtask : access
endmodule : vsbs_master_model
`default_nettype wire

//--- testbench/test_vme_short_io_board_select.sv
// Self-checking bench for the short I/O board select
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin badCount++; $display("ERROR %0t %h %h", $time, g, e); end end
module test_vme_short_io_board_select;
    import vsbs_pkg::*;
    logic        clk_sys, rst, ce, asValid, dsValid, lowFit, privFit, boardSel, outputReg, dtack;
    logic [15:1] addr;
    logic [5:0]  am, regIdx;
    logic [8:0]  upFit, b;
    int          badCount = 0, nCompared = 0, cycles = 0;
    vsbs_master_model bus (.clk_sys(clk_sys), .asValid(asValid), .dsValid(dsValid), .addr(addr), .am(am));
    vsbs_board_select dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .asValid(asValid), .dsValid(dsValid),
        .addr(addr), .am(am), .upper_base_address_jumpers_fitted(upFit), .low_base_address_jumper_fitted(lowFit),
        .privilege_select_jumper_fitted(privFit), .boardSel(boardSel), .regIdx(regIdx), .outputReg(outputReg),
        .dtack(dtack));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            badCount++;
            results();
        end
    end
    task automatic check(input logic [15:1] a, input logic [5:0] m, input logic s);
        bus.access(a, m, 1'b1);
        `CHK(boardSel, s)
        `CHK(dtack, s)
        if (s) `CHK(regIdx, a[6:1])
    endtask : check
    task automatic tStrobe();
        bus.access({b, 6'h22}, 6'h2D, 1'b0);
        `CHK(boardSel, 1'b1)
        `CHK(dtack, 1'b0)
    endtask : tStrobe
    task automatic tFreeze();
        @(posedge clk_sys) #1;
        ce = 1'b0;
        check({b, 6'h03}, 6'h2D, 1'b0);
        ce = 1'b1;
        bus.access({b, 6'h07}, 6'h2D, 1'b1);
        ce = 1'b0;
        @(posedge clk_sys) #1;
        `CHK(boardSel, 1'b1)
        `CHK(dtack, 1'b1)
        `CHK(regIdx, 6'h07)
        ce = 1'b1;
        @(posedge clk_sys) #1;
        `CHK(boardSel, 1'b0)
    endtask : tFreeze
    task automatic tReset();
        bus.access({b, 6'h2A}, 6'h2D, 1'b1);
        rst = 1'b1;
        @(posedge clk_sys) #1;
        `CHK(boardSel, 1'b0)
        `CHK(dtack, 1'b0)
        `CHK(regIdx, 6'h00)
        rst = 1'b0;
        check({b, 6'h2A}, 6'h2D, 1'b1);
        `CHK(outputReg, 1'b1)
    endtask : tReset
    task automatic tFactory();
        check(15'h0020, 6'h2D, 1'b1);
        `CHK(outputReg, 1'b1)
        check(15'h0001, 6'h2D, 1'b1);
        `CHK(outputReg, 1'b0)
    endtask : tFactory
    task automatic tPriv();
        check(15'h0020, 6'h29, 1'b0);
        privFit = 1'b1;
        check(15'h0020, 6'h29, 1'b1);
        check(15'h0020, 6'h2D, 1'b0);
        privFit = 1'b0;
    endtask : tPriv
    task automatic tBase();
        b = 9'h1A5;
        upFit = {~b[8:1], 1'b0};
        lowFit = ~b[0];
        check({b, 6'h05}, 6'h2D, 1'b1);
        for (int i = 0; i < 9; i++) check({b, 6'h05} ^ (15'h0040 << i), 6'h2D, 1'b0);
    endtask : tBase
    task automatic tIndex();
        for (int i = 0; i < 64; i++) begin
            check({b, i[5:0]}, 6'h2D, 1'b1);
            `CHK(outputReg, (i >= 32))
        end
    endtask : tIndex
    task automatic results();
        if (badCount == 0 && nCompared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        upFit = 9'h1FF;
        lowFit = 1'b1;
        privFit = 1'b0;
        repeat (20) @(posedge clk_sys);
        #1 rst = 1'b0;
        tFactory();
        tPriv();
        tBase();
        tIndex();
        tStrobe();
        tFreeze();
        tReset();
        results();
    end
endmodule : test_vme_short_io_board_select
`default_nettype wire
